// >>> logic/wcs_pkg.sv
// Package of constants and types for the winchester command sequencer.
// Overview of operation
// R1: Step code 0 is 35us, else code times 0.5ms.
// R2: Implied seeks use last Restore or Seek rate.
// R3: Long bit enables long mode; retry bit disables retries.
// R4: Idle holds drive lines off, ready, interrupt low; code keeps host_irq_o set after completion until the next command.
// R5: Host command byte is held in a latch.
// R6: Read command sets wake, busy and wake request.
// R7: Write or Format wakes after 512 or 516 bytes.
// R8: Wake leads to check, then issue to sequencer.
// R9: Completion interrupts controller, then ready and host interrupt.
// R10: Restore fails with track-zero error after 1023 steps.
// R11: Each restore step waits for seek complete.
// R12: Not ready or write fault aborts with error.
// R13: Seek goes to cylinder, latches rate, interrupts host.
// R14: Transfer 1 to 256 sectors across boundaries.
// R15: No rate yet: use 7.5ms and recalibrate first; code recalibrates for Read and Write only, Format seeks directly.
// R16: Off-cylinder transfers first do an implied seek.
// R17: Long-mode ECC bytes spaced at least 2us.
// R18: Correct up to 5-bit bursts; uncorrectable ends after sector.
// R19: Retry ten times, or two with retries off.
// R20: Up to eight ECC rereads; correct on matching syndromes.
// R21: Read interrupts per sector, none at the end.
// R22: Write interrupts for later sectors and at completion.
// R23: Stored step-rate field resets to 1111.
package wcs_pkg;
  localparam int CLK_HZ = 40000000;
  localparam int STEP_FAST_NS = 35000;
  localparam int STEP_UNIT_NS = 500000;
  localparam int ECC_GAP_NS = 2000;
  localparam int STEP_FAST_CYC = (STEP_FAST_NS * 40 + 999) / 1000;
  localparam int STEP_UNIT_CYC = (STEP_UNIT_NS / 1000) * (CLK_HZ / 1000000);
  localparam int ECC_GAP_CYC = (ECC_GAP_NS * 40 + 999) / 1000;
  localparam logic [3:0] STEP_RATE_RESET = 4'hf;
  localparam logic [9:0] RESTORE_MAX_STEPS = 10'h3ff;
  localparam logic [9:0] SECTOR_BYTES = 10'h200;
  localparam logic [9:0] SECTOR_BYTES_LONG = 10'h204;
  localparam logic [3:0] RETRY_ON = 4'ha;
  localparam logic [3:0] RETRY_OFF = 4'h2;
  localparam logic [3:0] ECC_REREADS = 4'h8;
  localparam logic [2:0] ECC_MAX_BURST = 3'h5;
  localparam logic [3:0] OP_RESTORE = 4'h1;
  localparam logic [3:0] OP_SEEK = 4'h7;
  localparam logic [3:0] OP_READ = 4'h2;
  localparam logic [3:0] OP_WRITE = 4'h3;
  localparam logic [3:0] OP_FORMAT = 4'h5;
  localparam int LONG_BIT = 1;
  localparam int RETRY_BIT = 0;
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_ABORT = 8'h04;
  localparam logic [7:0] ERR_TRK0 = 8'h02;
  localparam logic [7:0] ERR_ECC = 8'h40;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_FILL = 4'h1,
    ST_CHECK = 4'h2,
    ST_RECAL = 4'h3,
    ST_STEP_WAIT = 4'h4,
    ST_SEEK = 4'h5,
    ST_XFER = 4'h6,
    ST_ECC = 4'h7,
    ST_DONE = 4'h8
  } wcs_state_t;

  typedef struct packed {
    logic ready;
    logic write_fault;
    logic seek_done;
    logic track0;
  } wcs_drive_t;

  typedef struct packed {
    logic sector_ok;
    logic sector_err;
    logic ecc_err;
    logic [2:0] burst_len;
    logic [15:0] syndrome;
  } wcs_media_t;
endpackage

// >>> logic/wcs_sequencer.sv
// Command sequencer: intercept latch, wake logic, drive stepping and transfer.
`timescale 1ns/1ps
`default_nettype none
module wcs_sequencer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cmd_wr_i,
  input wire logic [7:0] cmd_i,
  input wire logic [15:0] cyl_target_i,
  input wire logic [7:0] sector_count_i,
  input wire logic in_valid_i,
  input wire logic [7:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [7:0] out_data_o,
  input wire logic out_ready_i,
  input wire logic [3:0] drive_i,
  input wire logic [21:0] media_i,
  input wire logic [7:0] media_data_i,
  output logic media_rd_o,
  output logic media_wr_o,
  output logic step_o,
  output logic step_out_o,
  output logic busy_o,
  output logic ready_o,
  output logic data_request_flag_o,
  output logic error_o,
  output logic [7:0] error_code_o,
  output logic corrected_o,
  output logic wake_o,
  output logic host_irq_o,
  output logic [3:0] step_rate_field_o
);
  logic [3:0] drv_s1, drv_s2;
  wcs_pkg::wcs_drive_t drv;
  wcs_pkg::wcs_media_t med;
  wcs_pkg::wcs_state_t state;
  logic [7:0] cmd_hold;
  logic rate_set;
  logic [9:0] byte_cnt;
  logic [9:0] step_cnt;
  logic [15:0] cyl_now;
  logic [8:0] sect_left;
  logic [3:0] tries;
  logic [3:0] ecc_tries;
  logic [15:0] last_syn;
  logic syn_valid;
  logic [19:0] timer;
  logic [19:0] step_period;
  logic [3:0] op;
  logic long_mode;
  logic retry_off;
  logic stop_after;
  logic [1:0] buf_cnt;
  logic [7:0] buf_mem [2];
  logic buf_wp, buf_rp;
  logic buf_push, buf_pop;
  logic [7:0] buf_din;
  logic ecc_phase;

  // Drive lines are asynchronous pins, so two flops first; media lines are used directly.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drv_s1 <= 4'h0;
      drv_s2 <= 4'h0;
    end else begin
      drv_s1 <= drive_i;
      drv_s2 <= drv_s1;
    end
  end
  assign drv = drv_s2;
  assign med = media_i;

  assign op = cmd_hold[7:4];
  assign long_mode = cmd_hold[wcs_pkg::LONG_BIT]; // see R3
  assign retry_off = cmd_hold[wcs_pkg::RETRY_BIT]; // see R3

  // see R1
  always_comb begin
    if (step_rate_field_o == 4'h0) begin
      step_period = 20'(wcs_pkg::STEP_FAST_CYC);
    end else begin
      step_period = 20'(wcs_pkg::STEP_UNIT_CYC) * {16'h0000, step_rate_field_o};
    end
  end

  // Two-entry buffer on the data path: a stalled receiver loses nothing.
  // Host bytes are only taken while the data request stands (see R17).
  assign in_ready_o = (buf_cnt != 2'h2) && (state == wcs_pkg::ST_FILL) &&
    data_request_flag_o;
  assign out_valid_o = (buf_cnt != 2'h0) && (op == wcs_pkg::OP_READ);
  assign out_data_o = buf_mem[buf_rp];
  // Write data goes on into the sector store, which is not modelled here.
  assign buf_pop = (op == wcs_pkg::OP_READ) ? (out_valid_o && out_ready_i) :
    (buf_cnt != 2'h0);
  always_comb begin
    buf_push = 1'b0;
    buf_din = media_data_i;
    if (state == wcs_pkg::ST_FILL) begin
      buf_push = in_valid_i && in_ready_o;
      buf_din = in_data_i;
    end else if (state == wcs_pkg::ST_XFER && op == wcs_pkg::OP_READ) begin
      buf_push = media_rd_o && (buf_cnt != 2'h2);
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      buf_cnt <= 2'h0;
      buf_wp <= 1'b0;
      buf_rp <= 1'b0;
      buf_mem[0] <= 8'h00;
      buf_mem[1] <= 8'h00;
    end else begin
      if (buf_push) begin
        buf_mem[buf_wp] <= buf_din;
        buf_wp <= ~buf_wp;
      end
      if (buf_pop) begin
        buf_rp <= ~buf_rp;
      end
      buf_cnt <= buf_cnt + 2'(buf_push) - 2'(buf_pop);
    end
  end

  // Held command byte and stored step rate.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_hold <= 8'h00;
      step_rate_field_o <= wcs_pkg::STEP_RATE_RESET; // see R23
      rate_set <= 1'b0;
    end else begin
      if (cmd_wr_i && state == wcs_pkg::ST_IDLE) begin
        cmd_hold <= cmd_i; // see R5
        if (cmd_i[7:4] == wcs_pkg::OP_RESTORE || cmd_i[7:4] == wcs_pkg::OP_SEEK) begin
          step_rate_field_o <= cmd_i[3:0]; // see R2, R13
          rate_set <= 1'b1;
        end
      end
      if (state == wcs_pkg::ST_CHECK && !rate_set) begin
        step_rate_field_o <= wcs_pkg::STEP_RATE_RESET; // see R15
        rate_set <= 1'b1;
      end
    end
  end

  // No byte moves in the cycle that ends a sector, so none spills over.
  assign media_rd_o = (state == wcs_pkg::ST_XFER) && op == wcs_pkg::OP_READ &&
    (timer == 20'h0) && (buf_cnt != 2'h2) && !med.sector_ok;
  assign media_wr_o = (state == wcs_pkg::ST_XFER) && op != wcs_pkg::OP_READ &&
    (timer == 20'h0) && !med.sector_ok;

  // Main sequence: wake, check, position, transfer, complete.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= wcs_pkg::ST_IDLE;
      byte_cnt <= 10'h000;
      step_cnt <= 10'h000;
      cyl_now <= 16'h0000;
      sect_left <= 9'h000;
      tries <= 4'h0;
      ecc_tries <= 4'h0;
      last_syn <= 16'h0000;
      syn_valid <= 1'b0;
      timer <= 20'h0;
      step_o <= 1'b0;
      step_out_o <= 1'b0;
      busy_o <= 1'b0;
      wake_o <= 1'b0;
      data_request_flag_o <= 1'b0;
      error_o <= 1'b0;
      error_code_o <= wcs_pkg::ERR_NONE;
      corrected_o <= 1'b0;
      host_irq_o <= 1'b0;
      stop_after <= 1'b0;
      ecc_phase <= 1'b0;
    end else begin
      step_o <= 1'b0;
      if (timer != 20'h0) begin
        timer <= timer - 20'h1;
      end
      // see R12
      if (state != wcs_pkg::ST_IDLE && state != wcs_pkg::ST_FILL &&
          state != wcs_pkg::ST_CHECK && state != wcs_pkg::ST_DONE &&
          (!drv.ready || drv.write_fault)) begin
        error_o <= 1'b1;
        error_code_o <= wcs_pkg::ERR_ABORT;
        state <= wcs_pkg::ST_DONE;
      end else begin
        case (state)
          wcs_pkg::ST_IDLE: begin
            busy_o <= 1'b0; // see R4
            if (cmd_wr_i) begin
              host_irq_o <= 1'b0;
              error_o <= 1'b0;
              error_code_o <= wcs_pkg::ERR_NONE;
              corrected_o <= 1'b0;
              byte_cnt <= 10'h000;
              sect_left <= (sector_count_i == 8'h00) ? 9'h100 : {1'b0, sector_count_i}; // see R14
              if (cmd_i[7:4] == wcs_pkg::OP_WRITE || cmd_i[7:4] == wcs_pkg::OP_FORMAT) begin
                data_request_flag_o <= 1'b1; // see R7
                state <= wcs_pkg::ST_FILL;
              end else begin
                wake_o <= 1'b1; // see R6
                busy_o <= 1'b1;
                state <= wcs_pkg::ST_CHECK;
              end
            end
          end
          wcs_pkg::ST_FILL: begin
            if (buf_push) begin
              // see R17
              if (byte_cnt >= wcs_pkg::SECTOR_BYTES) begin
                data_request_flag_o <= 1'b0;
                timer <= 20'(wcs_pkg::ECC_GAP_CYC);
              end
              byte_cnt <= byte_cnt + 10'h1;
              if (byte_cnt + 10'h1 == (long_mode ? wcs_pkg::SECTOR_BYTES_LONG : wcs_pkg::SECTOR_BYTES)) begin
                data_request_flag_o <= 1'b0;
                wake_o <= 1'b1; // see R7
                busy_o <= 1'b1;
                host_irq_o <= 1'b0;
                state <= wcs_pkg::ST_CHECK;
              end
            end else if (byte_cnt >= wcs_pkg::SECTOR_BYTES && timer == 20'h0) begin
              data_request_flag_o <= 1'b1;
            end
          end
          wcs_pkg::ST_CHECK: begin
            // see R8
            wake_o <= 1'b0;
            tries <= 4'h0;
            ecc_tries <= 4'h0;
            syn_valid <= 1'b0;
            step_cnt <= 10'h000;
            if (op == wcs_pkg::OP_RESTORE || ((op == wcs_pkg::OP_READ || op == wcs_pkg::OP_WRITE) && !rate_set)) begin
              state <= wcs_pkg::ST_RECAL; // see R15
            end else if (op == wcs_pkg::OP_SEEK || op == wcs_pkg::OP_READ || op == wcs_pkg::OP_WRITE || op == wcs_pkg::OP_FORMAT) begin
              state <= wcs_pkg::ST_SEEK;
            end else begin
              error_o <= 1'b1;
              error_code_o <= wcs_pkg::ERR_ABORT;
              state <= wcs_pkg::ST_DONE;
            end
          end
          wcs_pkg::ST_RECAL: begin
            if (drv.track0) begin
              cyl_now <= 16'h0000; // see R10
              state <= (op == wcs_pkg::OP_RESTORE) ? wcs_pkg::ST_DONE : wcs_pkg::ST_SEEK;
            end else if (step_cnt == wcs_pkg::RESTORE_MAX_STEPS) begin
              error_o <= 1'b1;
              error_code_o <= wcs_pkg::ERR_TRK0;
              state <= wcs_pkg::ST_DONE;
            end else if (drv.seek_done) begin
              step_o <= 1'b1; // see R11
              step_out_o <= 1'b1;
              step_cnt <= step_cnt + 10'h1;
              state <= wcs_pkg::ST_STEP_WAIT;
            end
          end
          wcs_pkg::ST_STEP_WAIT: begin
            // Seek complete drops after a step; wait for that before rechecking.
            if (!drv.seek_done) begin
              state <= wcs_pkg::ST_RECAL;
            end
          end
          wcs_pkg::ST_SEEK: begin
            // see R16, R13
            if (cyl_now == cyl_target_i) begin
              if (op == wcs_pkg::OP_SEEK) begin
                state <= wcs_pkg::ST_DONE;
              end else begin
                byte_cnt <= 10'h000;
                state <= wcs_pkg::ST_XFER;
              end
            end else if (timer == 20'h0) begin
              step_o <= 1'b1;
              step_out_o <= (cyl_target_i < cyl_now);
              cyl_now <= (cyl_target_i < cyl_now) ? cyl_now - 16'h1 : cyl_now + 16'h1;
              timer <= step_period; // see R2
            end
          end
          wcs_pkg::ST_XFER: begin
            if (med.sector_err) begin
              // see R19
              if (tries + 4'h1 >= (retry_off ? wcs_pkg::RETRY_OFF : wcs_pkg::RETRY_ON)) begin
                error_o <= 1'b1;
                error_code_o <= wcs_pkg::ERR_ABORT;
                state <= wcs_pkg::ST_DONE;
              end
              tries <= tries + 4'h1;
            end else if (med.ecc_err && !long_mode) begin
              state <= wcs_pkg::ST_ECC;
            end else if (med.sector_ok) begin
              sect_left <= sect_left - 9'h1;
              tries <= 4'h0;
              ecc_tries <= 4'h0;
              syn_valid <= 1'b0;
              if (op == wcs_pkg::OP_READ) begin
                host_irq_o <= 1'b1; // see R21
                data_request_flag_o <= 1'b1;
              end
              if (sect_left == 9'h001 || stop_after || op == wcs_pkg::OP_FORMAT) begin
                state <= wcs_pkg::ST_DONE; // see R18
              end else if (op == wcs_pkg::OP_WRITE) begin
                host_irq_o <= 1'b1; // see R22
                byte_cnt <= 10'h000;
                data_request_flag_o <= 1'b1;
                state <= wcs_pkg::ST_FILL;
              end
            end
            if (media_rd_o && long_mode) begin
              timer <= 20'(wcs_pkg::ECC_GAP_CYC); // see R17
            end
          end
          wcs_pkg::ST_ECC: begin
            // see R20
            syn_valid <= 1'b1;
            last_syn <= med.syndrome;
            if (syn_valid && last_syn == med.syndrome && med.burst_len <= wcs_pkg::ECC_MAX_BURST) begin
              corrected_o <= 1'b1; // see R18
              state <= wcs_pkg::ST_XFER;
            end else if (ecc_tries + 4'h1 >= wcs_pkg::ECC_REREADS) begin
              error_o <= 1'b1;
              error_code_o <= wcs_pkg::ERR_ECC;
              stop_after <= 1'b1;
              state <= wcs_pkg::ST_XFER;
            end else begin
              ecc_tries <= ecc_tries + 4'h1;
              state <= wcs_pkg::ST_XFER;
            end
          end
          wcs_pkg::ST_DONE: begin
            // see R9
            busy_o <= 1'b0;
            stop_after <= 1'b0;
            data_request_flag_o <= 1'b0;
            if (!(op == wcs_pkg::OP_READ && !error_o)) begin
              host_irq_o <= 1'b1;
            end
            state <= wcs_pkg::ST_IDLE;
          end
          default: begin
            state <= wcs_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  assign ready_o = !busy_o && drv.ready; // see R4
endmodule
`default_nettype wire

// >>> verif/wcs_drive_model.sv
// Behavioural fixed disk: head position, seek settling and sector media.
`timescale 1ns/1ps
`default_nettype none
module wcs_drive_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ready_ok_i,
  input wire logic fault_i,
  input wire logic step_i,
  input wire logic step_out_i,
  input wire logic media_rd_i,
  input wire logic media_wr_i,
  output logic [3:0] drive_o,
  output logic [21:0] media_o,
  output logic [7:0] media_data_o,
  output logic [15:0] cyl_o
);
  logic [2:0] settle;
  logic [9:0] count;
  logic sector_ok;
  // Seek complete drops after every step, so pacing is really exercised.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cyl_o <= 16'h0003;
      settle <= 3'h0;
    end else if (step_i) begin
      if (!step_out_i) begin
        cyl_o <= cyl_o + 16'h0001;
      end else if (cyl_o != 16'h0000) begin
        cyl_o <= cyl_o - 16'h0001;
      end
      settle <= 3'h7;
    end else if (settle != 3'h0) begin
      settle <= settle - 3'h1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count <= 10'h000;
      sector_ok <= 1'b0;
    end else begin
      sector_ok <= 1'b0;
      if (media_rd_i || media_wr_i) begin
        count <= (count == 10'h1ff) ? 10'h000 : count + 10'h001;
        sector_ok <= (count == 10'h1ff);
      end
    end
  end
  assign media_data_o = count[7:0];
  assign drive_o = {ready_ok_i, fault_i, settle == 3'h0, cyl_o == 16'h0};
  assign media_o = {sector_ok, 21'h000000};
endmodule
`default_nettype wire

// >>> verif/wcs_sequencer_assertions.sv
// Port-level timing checks for the command sequencer.
`timescale 1ns/1ps
`default_nettype none
module wcs_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cmd_wr_i,
  input wire logic [7:0] cmd_i,
  input wire logic [3:0] drive_i,
  input wire logic out_ready_i,
  input wire logic out_valid_o,
  input wire logic [7:0] out_data_o,
  input wire logic step_o,
  input wire logic media_rd_o,
  input wire logic busy_o,
  input wire logic ready_o,
  input wire logic data_request_flag_o,
  input wire logic error_o,
  input wire logic [7:0] error_code_o,
  input wire logic wake_o,
  input wire logic host_irq_o,
  input wire logic [3:0] step_rate_field_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic idle;
  assign idle = !busy_o && !data_request_flag_o;
  property p_rate_reset;
    $fell(rst_i) |-> step_rate_field_o == wcs_pkg::STEP_RATE_RESET;
  endproperty
  a_rate_reset: assert property (p_rate_reset)
    else $error("step rate not slowest after reset");
  property p_read_wake;
    idle && cmd_wr_i && cmd_i[7:4] == wcs_pkg::OP_READ |=> busy_o && wake_o;
  endproperty
  a_read_wake: assert property (p_read_wake)
    else $error("read command did not wake");
  property p_write_drq;
    idle && cmd_wr_i && cmd_i[7:4] == wcs_pkg::OP_WRITE
      |=> data_request_flag_o && !busy_o && !wake_o;
  endproperty
  a_write_drq: assert property (p_write_drq)
    else $error("write command did not request data first");
  property p_wake_pulse;
    wake_o |=> !wake_o;
  endproperty
  a_wake_pulse: assert property (p_wake_pulse)
    else $error("wake request longer than one cycle");
  property p_idle_quiet;
    idle && $past(idle) |-> !step_o && !media_rd_o;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("drive activity while idle");
  property p_ready;
    ready_o |-> !busy_o;
  endproperty
  a_ready: assert property (p_ready)
    else $error("ready shown while busy");
  property p_abort;
    (busy_o && !drive_i[3]) [*4]
      |-> ##[0:8] error_o && error_code_o == wcs_pkg::ERR_ABORT;
  endproperty
  a_abort: assert property (p_abort)
    else $error("no abort on lost drive ready");
  property p_irq_done;
    $fell(busy_o) && !error_o |-> host_irq_o;
  endproperty
  a_irq_done: assert property (p_irq_done)
    else $error("completion without host interrupt");
  property p_hold;
    out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o);
  endproperty
  a_hold: assert property (p_hold)
    else $error("read word lost during stall");
  property p_step_pulse;
    step_o |=> !step_o;
  endproperty
  a_step_pulse: assert property (p_step_pulse)
    else $error("step pulse too long");
endmodule
`default_nettype wire

// >>> verif/wcs_sequencer_tb.sv
// Self-checking bench for the command sequencer with a drive model.
`timescale 1ns/1ps
`default_nettype none
module wcs_sequencer_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cmd_wr_i = 1'b0;
  logic [7:0] cmd_i = 8'h00;
  logic [15:0] cyl_target_i = 16'h0000;
  logic [7:0] sector_count_i = 8'h02;
  logic in_valid_i = 1'b0;
  logic [7:0] in_data_i = 8'h00;
  logic out_ready_i = 1'b0;
  logic ready_ok = 1'b1;
  logic fault = 1'b0;
  wire in_ready_o, out_valid_o, media_rd_o, media_wr_o, step_o, step_out_o;
  wire busy_o, ready_o, data_request_flag_o, error_o, corrected_o;
  wire wake_o, host_irq_o;
  wire [7:0] out_data_o, error_code_o, media_data_i;
  wire [3:0] drive_i, step_rate_field_o;
  wire [21:0] media_i;
  wire [15:0] cyl;
  int bad_count = 0;
  int samples_checked = 0;
  always #12.5 clk_i = ~clk_i;
  wcs_sequencer u_wcs_sequencer (.clk_i, .rst_i, .cmd_wr_i, .cmd_i,
    .cyl_target_i, .sector_count_i, .in_valid_i, .in_data_i, .in_ready_o,
    .out_valid_o, .out_data_o, .out_ready_i, .drive_i, .media_i,
    .media_data_i, .media_rd_o, .media_wr_o, .step_o, .step_out_o, .busy_o,
    .ready_o, .data_request_flag_o, .error_o, .error_code_o, .corrected_o,
    .wake_o, .host_irq_o, .step_rate_field_o);
  wcs_drive_model u_wcs_drive_model (.clk_i, .rst_i, .ready_ok_i(ready_ok),
    .fault_i(fault), .step_i(step_o), .step_out_i(step_out_o),
    .media_rd_i(media_rd_o), .media_wr_i(media_wr_o), .drive_o(drive_i),
    .media_o(media_i), .media_data_o(media_data_i), .cyl_o(cyl));
  task automatic report_and_stop;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bound(input int n);
    if (n > 40000) begin
      bad_count++;
      report_and_stop();
    end
  endtask
  task automatic issue(input logic [7:0] c);
    @(posedge clk_i);
    cmd_i <= c;
    cmd_wr_i <= 1'b1;
    @(posedge clk_i);
    cmd_wr_i <= 1'b0;
    #1;
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    while (busy_o === 1'b1) begin
      @(posedge clk_i);
      n++;
      bound(n);
    end
    #1;
  endtask
  // Valid and data hold until the edge that sees ready, so no byte is lost.
  task automatic send(input int nb);
    int n;
    for (int i = 0; i < nb; i++) begin
      in_data_i <= 8'(i);
      in_valid_i <= 1'b1;
      n = 0;
      do begin
        @(posedge clk_i);
        n++;
        bound(n);
      end while (in_ready_o !== 1'b1);
    end
    in_valid_i <= 1'b0;
  endtask
  // Ready drops one cycle in four to make the buffer hold a word.
  task automatic drain(input int nb);
    int got;
    int n;
    got = 0;
    n = 0;
    while (got < nb) begin
      out_ready_i <= (n % 4 != 0);
      @(posedge clk_i);
      if (out_valid_o === 1'b1 && out_ready_i === 1'b1) begin
        chk({8'h00, out_data_o}, 16'(got & 255));
        got++;
      end
      n++;
      bound(n);
    end
    out_ready_i <= 1'b0;
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
    chk({12'h000, step_rate_field_o}, 16'h000f);
    chk({12'h000, busy_o, ready_o, host_irq_o, step_o}, 16'h0004);
    issue(8'h10);
    wait_idle();
    chk({12'h000, step_rate_field_o}, 16'h0000);
    chk(cyl, 16'h0000);
    chk({14'h0000, error_o, host_irq_o}, 16'h0001);
    cyl_target_i <= 16'h0006;
    issue(8'h70);
    repeat (4) @(posedge clk_i);
    issue(8'h7f);
    wait_idle();
    chk(cyl, 16'h0006);
    chk({11'h000, host_irq_o, step_rate_field_o}, 16'h0010);
    issue(8'h20);
    chk({14'h0000, busy_o, wake_o}, 16'h0003);
    drain(1024);
    wait_idle();
    chk({14'h0000, error_o, host_irq_o}, 16'h0001);
    sector_count_i <= 8'h01;
    issue(8'h30);
    chk({14'h0000, busy_o, data_request_flag_o}, 16'h0001);
    send(511);
    @(posedge clk_i);
    chk({15'h0000, busy_o}, 16'h0000);
    send(1);
    repeat (3) @(posedge clk_i);
    #1;
    chk({15'h0000, busy_o}, 16'h0001);
    wait_idle();
    chk({14'h0000, error_o, host_irq_o}, 16'h0001);
    for (int k = 0; k < 2; k++) begin
      ready_ok <= (k == 1);
      fault <= (k == 1);
      issue(8'h10);
      wait_idle();
      chk({7'h00, error_o, error_code_o}, 16'h0104);
    end
    report_and_stop();
  end
endmodule
bind wcs_sequencer wcs_checker u_wcs_checker (.clk_i, .rst_i, .cmd_wr_i,
  .cmd_i, .drive_i, .out_ready_i, .out_valid_o, .out_data_o, .step_o,
  .media_rd_o, .busy_o, .ready_o, .data_request_flag_o, .error_o,
  .error_code_o, .wake_o, .host_irq_o, .step_rate_field_o);
`default_nettype wire
